/* File: src/fts_channel.sv */
`timescale 1ns/100ps
// One latched supervision channel with hysteresis-guarded reset
module fts_channel
  import fts_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] hyst_i,
  input wire logic reset_req_i,
  output logic live_o,
  output logic fault_o
);

  logic [16:0] release_level;
  logic clear_ok;

  // ==========================================================
  // Compare
  // ==========================================================
  // Wide subtraction avoids a wrap when hysteresis exceeds level
  assign release_level = {1'b0, level_i} - {1'b0, hyst_i};
  assign live_o = enable_i && (value_i > level_i);
  assign clear_ok = !live_o &&
    (release_level[16] || ({1'b0, value_i} < release_level) ||
     (hyst_i == 16'h0000));

  // Latch; a live condition wins over a reset request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if (live_o) begin
      fault_o <= 1'b1;
    end else if (reset_req_i && clear_ok) begin
      fault_o <= 1'b0;
    end
  end

endmodule

/* File: src/fts_pkg.sv */
package fts_pkg;

  // ==========================================================
  // Register map (byte address, word index = address / 4)
  // ==========================================================
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_DEV_LEVELS = 8'h04;
  localparam logic [7:0] ADDR_PTC_ACTION = 8'h08;
  localparam logic [7:0] ADDR_AIN_ACTION = 8'h0C;
  localparam logic [7:0] ADDR_PTC_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_AIN_LEVEL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_MASK = 8'h34;
  localparam logic [7:0] ADDR_FAULT = 8'h38;
  localparam logic [7:0] ADDR_LIVE = 8'h3C;
  localparam logic [7:0] ADDR_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_DEVIATION = 8'h44;
  localparam logic [7:0] ADDR_ID = 8'h48;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CFG_GEARBOX_LSB = 0;
  localparam int CFG_ENCODER_LSB = 4;
  localparam int LVL_HYST_LSB = 8;
  localparam int DEV_SOFT_LSB = 16;
  localparam int CTRL_RESET_BIT = 0;

  // ==========================================================
  // Reset values and encodings
  // ==========================================================
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;
  localparam logic [3:0] ENCODER_DUAL = 4'h2;
  localparam logic [3:0] GEARBOX_OK_A = 4'h1;
  localparam logic [3:0] GEARBOX_OK_B = 4'h5;
  localparam logic [3:0] GEARBOX_OK_C = 4'h6;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_BOTH = 2'h1;
  localparam logic [1:0] ACT_A = 2'h2;
  localparam logic [1:0] ACT_B = 2'h3;
  // Arbitrary identification value
  localparam logic [31:0] BLOCK_ID = 32'h0000_F75A;

  // Analogue code: signed 16 bit, full scale maps to 100.00 percent
  localparam int AIN_W = 16;
  localparam logic [15:0] PCT_FULL = 16'h2710;

  typedef enum logic [1:0] {FTS_IDLE, FTS_TRIPPED, FTS_HOLD} fts_state_type;

endpackage

/* File: src/fts_top.sv */
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module fts_top
  import fts_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0] overspeed_trip_i,
  input wire logic [3:0] overspeed_soft_i,
  input wire logic [15:0] height1_mm_i,
  input wire logic [15:0] height2_mm_i,
  input wire logic [63:0] thermistor_i,
  input wire logic [63:0] analog_i,
  input wire logic reset_action_i,
  output logic motor1_overspeed_trip_flag_o,
  output logic motor2_overspeed_trip_flag_o,
  output logic drum1_overspeed_trip_flag_o,
  output logic drum2_overspeed_trip_flag_o,
  output logic motor1_overspeed_soft_flag_o,
  output logic motor2_overspeed_soft_flag_o,
  output logic drum1_overspeed_soft_flag_o,
  output logic drum2_overspeed_soft_flag_o,
  output logic height_deviation_trip_fault_o,
  output logic height_deviation_soft_fault_o,
  output logic [3:0] thermistor_soft_indication_o,
  output logic [3:0] analog_soft_indication_o,
  output logic safety_output_o,
  output logic soft_stop_output_a_o,
  output logic soft_stop_output_b_o,
  output logic irq_o
);

  // Decode an action code into the two soft-stop opening requests
  function automatic logic [1:0] action_opens(input logic [1:0] act);
    case (act)
      ACT_BOTH: action_opens = 2'b11;
      ACT_A: action_opens = 2'b01;
      ACT_B: action_opens = 2'b10;
      default: action_opens = 2'b00;
    endcase
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] config_reg;
  logic [31:0] dev_levels;
  logic [7:0] ptc_action;
  logic [7:0] ain_action;
  logic [31:0] ptc_level [4];
  logic [31:0] ain_level [4];
  logic [11:0] irq_status;
  logic [11:0] irq_mask;
  logic sw_reset;
  fts_state_type dev_state;

  // ==========================================================
  // Input synchronisers (three stages, change on 2nd/3rd agree)
  // ==========================================================
  logic [9:0] pin_s1, pin_s2, pin_s3;
  logic [9:0] pin_clean;
  logic [9:0] pin_raw;
  assign pin_raw = {reset_action_i, overspeed_soft_i, overspeed_trip_i,
                    1'b0};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 10'h000;
      pin_s2 <= 10'h000;
      pin_s3 <= 10'h000;
      pin_clean <= 10'h000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
    end
  end

  // Multi-bit measurements are sampled twice; words may tear by one
  // sample, which the level compare tolerates.
  logic [15:0] h1_s1, h1_s2, h2_s1, h2_s2;
  logic [63:0] ptc_s1, ptc_s2, ain_s1, ain_s2;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      h1_s1 <= 16'h0000;
      h1_s2 <= 16'h0000;
      h2_s1 <= 16'h0000;
      h2_s2 <= 16'h0000;
      ptc_s1 <= 64'h0000_0000_0000_0000;
      ptc_s2 <= 64'h0000_0000_0000_0000;
      ain_s1 <= 64'h0000_0000_0000_0000;
      ain_s2 <= 64'h0000_0000_0000_0000;
    end else begin
      h1_s1 <= height1_mm_i;
      h1_s2 <= h1_s1;
      h2_s1 <= height2_mm_i;
      h2_s2 <= h2_s1;
      ptc_s1 <= thermistor_i;
      ptc_s2 <= ptc_s1;
      ain_s1 <= analog_i;
      ain_s2 <= ain_s1;
    end
  end

  logic reset_req;
  logic reset_prev;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reset_prev <= 1'b0;
    end else begin
      reset_prev <= pin_clean[9];
    end
  end
  // Reset action is the rising edge of the pin or a software pulse
  assign reset_req = (pin_clean[9] && !reset_prev) || sw_reset;

  // ==========================================================
  // Overspeed flags latched until a reset action
  // ==========================================================
  logic [3:0] os_trip, os_soft;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      os_trip <= 4'h0;
      os_soft <= 4'h0;
    end else begin
      os_trip <= pin_clean[4:1] | (reset_req ? 4'h0 : os_trip);
      os_soft <= pin_clean[8:5] | (reset_req ? 4'h0 : os_soft);
    end
  end

  // ==========================================================
  // Height deviation
  // ==========================================================
  logic dev_enable;
  logic signed [16:0] deviation;
  logic [3:0] gearbox;
  assign gearbox = config_reg[CFG_GEARBOX_LSB +: 4];
  assign dev_enable = (gearbox == GEARBOX_OK_A || gearbox == GEARBOX_OK_B ||
    gearbox == GEARBOX_OK_C) &&
    (config_reg[CFG_ENCODER_LSB +: 4] == ENCODER_DUAL);
  assign deviation = $signed({h1_s2[15], h1_s2}) -
                     $signed({h2_s2[15], h2_s2});

  logic dev_trip_live, dev_soft_live;
  assign dev_trip_live = dev_enable &&
    (deviation > $signed({1'b0, dev_levels[15:0]}));
  // Soft level is 14 bits; the top two bits hold the action code
  assign dev_soft_live = dev_enable &&
    (deviation > $signed({3'b000, dev_levels[DEV_SOFT_LSB +: 14]}));

  logic dev_trip, dev_soft;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dev_trip <= 1'b0;
      dev_soft <= 1'b0;
    end else begin
      dev_trip <= dev_trip_live || (dev_trip && !reset_req);
      dev_soft <= dev_soft_live || (dev_soft && !reset_req);
    end
  end

  // Small state view of the deviation supervisor for software
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dev_state <= FTS_IDLE;
    end else begin
      case (dev_state)
        FTS_IDLE:
          if (dev_trip_live || dev_soft_live) dev_state <= FTS_TRIPPED;
        FTS_TRIPPED:
          if (!dev_trip_live && !dev_soft_live) dev_state <= FTS_HOLD;
        FTS_HOLD: begin
          if (dev_trip_live || dev_soft_live) begin
            dev_state <= FTS_TRIPPED;
          end else if (reset_req) begin
            dev_state <= FTS_IDLE;
          end
        end
        default: dev_state <= FTS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Thermistor and analogue channels
  // ==========================================================
  logic [3:0] ptc_live, ptc_fault, ain_live, ain_fault;
  logic [15:0] ain_pct [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      logic [15:0] raw;
      logic [15:0] mag;
      logic [31:0] prod;
      assign raw = ain_s2[16*g +: 16];
      // Absolute value, then scale so full scale reads 100.00 percent
      assign mag = raw[15] ? (~raw + 16'h0001) : raw;
      assign prod = mag * PCT_FULL;
      assign ain_pct[g] = (prod[30:15] > PCT_FULL) ? PCT_FULL : prod[30:15];

      // Reaching the level trips, hence reading plus one for a > compare
      fts_channel u_ptc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(ptc_action[2*g +: 2] != ACT_OFF),
        .value_i(ptc_s2[16*g +: 16] + 16'h0001),
        .level_i(ptc_level[g][15:0]),
        .hyst_i(ptc_level[g][LVL_HYST_LSB +: 8] == 8'h00 ? 16'h0000 :
                {8'h00, ptc_level[g][LVL_HYST_LSB +: 8]} +
                16'h0001),
        .reset_req_i(reset_req),
        .live_o(ptc_live[g]),
        .fault_o(ptc_fault[g])
      );
      fts_channel u_ain (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(ain_action[2*g +: 2] != ACT_OFF),
        .value_i(ain_pct[g]),
        .level_i(ain_level[g][15:0]),
        .hyst_i(ain_level[g][31:16]),
        .reset_req_i(reset_req),
        .live_o(ain_live[g]),
        .fault_o(ain_fault[g])
      );
    end
  endgenerate

  // ==========================================================
  // Output relays (1 = relay closed, opened on fault)
  // ==========================================================
  logic [1:0] open_req;
  always_comb begin
    open_req = 2'b00;
    if (dev_soft) open_req = open_req | action_opens(dev_levels[31:30]);
    for (int i = 0; i < 4; i++) begin
      if (ptc_fault[i])
        open_req = open_req | action_opens(ptc_action[2*i +: 2]);
      if (ain_fault[i])
        open_req = open_req | action_opens(ain_action[2*i +: 2]);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      safety_output_o <= 1'b0;
      soft_stop_output_a_o <= 1'b0;
      soft_stop_output_b_o <= 1'b0;
      thermistor_soft_indication_o <= 4'h0;
      analog_soft_indication_o <= 4'h0;
    end else begin
      safety_output_o <= !(dev_trip || (|os_trip));
      soft_stop_output_a_o <= !(open_req[0] || (|os_soft));
      soft_stop_output_b_o <= !(open_req[1] || (|os_soft));
      thermistor_soft_indication_o <= ptc_live;
      analog_soft_indication_o <= ain_live;
    end
  end

  assign motor1_overspeed_trip_flag_o = os_trip[0];
  assign motor2_overspeed_trip_flag_o = os_trip[1];
  assign drum1_overspeed_trip_flag_o = os_trip[2];
  assign drum2_overspeed_trip_flag_o = os_trip[3];
  assign motor1_overspeed_soft_flag_o = os_soft[0];
  assign motor2_overspeed_soft_flag_o = os_soft[1];
  assign drum1_overspeed_soft_flag_o = os_soft[2];
  assign drum2_overspeed_soft_flag_o = os_soft[3];
  assign height_deviation_trip_fault_o = dev_trip;
  assign height_deviation_soft_fault_o = dev_soft;

  // ==========================================================
  // Interrupt status: set wins over write-one-to-clear
  // ==========================================================
  logic [11:0] events;
  assign events = {ain_live, ptc_live, dev_soft_live, dev_trip_live,
                   |pin_clean[8:5], |pin_clean[4:1]};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= 12'h000;
      irq_o <= 1'b0;
    end else begin
      irq_status <= events | (irq_status &
        ~((write_i && addr_i == ADDR_STATUS) ? wdata_i[11:0] : 12'h000));
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Register writes
  // ==========================================================
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      config_reg <= CONFIG_RESET;
      dev_levels <= LEVEL_RESET;
      ptc_action <= 8'h00;
      ain_action <= 8'h00;
      irq_mask <= 12'h000;
      sw_reset <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ptc_level[i] <= LEVEL_RESET;
        ain_level[i] <= LEVEL_RESET;
      end
    end else begin
      sw_reset <= write_i && addr_i == ADDR_CONTROL && wdata_i[CTRL_RESET_BIT];
      if (write_i) begin
        case (addr_i)
          ADDR_CONFIG: config_reg <= wdata_i;
          ADDR_DEV_LEVELS: dev_levels <= wdata_i;
          ADDR_PTC_ACTION: ptc_action <= wdata_i[7:0];
          ADDR_AIN_ACTION: ain_action <= wdata_i[7:0];
          ADDR_MASK: irq_mask <= wdata_i[11:0];
          default: begin
            if (addr_i[7:4] == ADDR_PTC_LEVEL[7:4]) begin
              ptc_level[addr_i[3:2]] <= wdata_i;
            end else if (addr_i[7:4] == ADDR_AIN_LEVEL[7:4]) begin
              ain_level[addr_i[3:2]] <= wdata_i;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads, data valid the cycle after the strobe
  // ==========================================================
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (read_i) begin
      case (addr_i)
        ADDR_CONFIG: rdata_o <= config_reg;
        ADDR_DEV_LEVELS: rdata_o <= dev_levels;
        ADDR_PTC_ACTION: rdata_o <= {24'h00_0000, ptc_action};
        ADDR_AIN_ACTION: rdata_o <= {24'h00_0000, ain_action};
        ADDR_STATUS: rdata_o <= {20'h0_0000, irq_status};
        ADDR_MASK: rdata_o <= {20'h0_0000, irq_mask};
        ADDR_FAULT: rdata_o <= {12'h000, dev_state, ain_fault, ptc_fault,
                                dev_soft, dev_trip, os_soft, os_trip};
        ADDR_LIVE: rdata_o <= {24'h00_0000, ain_live, ptc_live};
        ADDR_DEVIATION: rdata_o <= {{15{deviation[16]}}, deviation};
        ADDR_ID: rdata_o <= BLOCK_ID;
        default: begin
          if (addr_i[7:4] == ADDR_PTC_LEVEL[7:4]) begin
            rdata_o <= ptc_level[addr_i[3:2]];
          end else if (addr_i[7:4] == ADDR_AIN_LEVEL[7:4]) begin
            rdata_o <= ain_level[addr_i[3:2]];
          end else begin
            rdata_o <= 32'h0000_0000;
          end
        end
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule

/* File: tb/fts_checker.sv */
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of the supervisor
module fts_checker
  import fts_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic [3:0] overspeed_trip_i,
  input wire logic [3:0] overspeed_soft_i,
  input wire logic [15:0] height1_mm_i,
  input wire logic [15:0] height2_mm_i,
  input wire logic [63:0] analog_i,
  input wire logic reset_action_i,
  input wire logic motor1_overspeed_trip_flag_o,
  input wire logic motor1_overspeed_soft_flag_o,
  input wire logic height_deviation_trip_fault_o,
  input wire logic height_deviation_soft_fault_o,
  input wire logic [3:0] analog_soft_indication_o,
  input wire logic safety_output_o,
  input wire logic soft_stop_output_a_o,
  input wire logic soft_stop_output_b_o
);
  logic [5:0] since_req;
  // Cycles since a reset request; saturates so old requests count as none
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      since_req <= 6'h3F;
    end else if (reset_action_i || (write_i && addr_i == ADDR_CONTROL &&
                 wdata_i[CTRL_RESET_BIT])) begin
      since_req <= 6'h00;
    end else if (since_req != 6'h3F) begin
      since_req <= since_req + 6'h01;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Eight cycles outlast the pin synchronisers and the output register
  sequence trip_held;
    overspeed_trip_i[0] [*8];
  endsequence
  sequence soft_held;
    overspeed_soft_i[0] [*8];
  endsequence
  sequence ain_quiet;
    (analog_i[15:0] == 16'h0000) [*8];
  endsequence
  sequence heights_equal;
    (height1_mm_i == height2_mm_i) [*8];
  endsequence
  sequence any_fall;
    $fell(motor1_overspeed_trip_flag_o) || $fell(motor1_overspeed_soft_flag_o)
    || $fell(height_deviation_trip_fault_o)
    || $fell(height_deviation_soft_fault_o);
  endsequence
  trip_flag_set_a: assert property (trip_held |->
    motor1_overspeed_trip_flag_o && !safety_output_o)
    else $error("trip flag or safety output wrong");
  trip_flag_hold_a: assert property (
    motor1_overspeed_trip_flag_o && since_req == 6'h3F |=>
    motor1_overspeed_trip_flag_o) else $error("trip flag dropped");
  soft_flag_set_a: assert property (soft_held |->
    motor1_overspeed_soft_flag_o && !soft_stop_output_a_o &&
    !soft_stop_output_b_o) else $error("soft flag or outputs wrong");
  soft_flag_hold_a: assert property (
    motor1_overspeed_soft_flag_o && since_req == 6'h3F |=>
    motor1_overspeed_soft_flag_o) else $error("soft flag dropped");
  dev_safety_a: assert property (
    $rose(height_deviation_trip_fault_o) |-> ##[0:2] !safety_output_o)
    else $error("safety output stayed closed");
  fault_clear_a: assert property (any_fall |-> since_req < 6'h10)
    else $error("fault cleared without reset request");
  ain_quiet_a: assert property (ain_quiet |->
    !analog_soft_indication_o[0]) else $error("zero input tripped");
  dev_equal_a: assert property (heights_equal |->
    !$rose(height_deviation_soft_fault_o)) else $error("equal heights trip");
endmodule
bind fts_top fts_checker fts_checker_i (.clock_i, .rst_i, .addr_i, .wdata_i,
  .write_i, .overspeed_trip_i, .overspeed_soft_i, .height1_mm_i,
  .height2_mm_i, .analog_i, .reset_action_i, .motor1_overspeed_trip_flag_o,
  .motor1_overspeed_soft_flag_o, .height_deviation_trip_fault_o,
  .height_deviation_soft_fault_o, .analog_soft_indication_o,
  .safety_output_o, .soft_stop_output_a_o, .soft_stop_output_b_o);

/* File: tb/fts_sensor_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Sensor side: converter for four analogue inputs, thermistor readings
module fts_sensor_model (
  input wire logic clock_i,
  input wire logic [63:0] mv_i,
  input wire logic [63:0] ptc_i,
  output logic [63:0] analog_o,
  output logic [63:0] thermistor_o
);
  // Plus and minus 10000 mV span the signed code range
  function automatic logic [15:0] adc(input logic [15:0] mv);
    return 16'(($signed(mv) * 32767) / 10000);
  endfunction
  // A new conversion each clock, like a free-running converter
  always_ff @(posedge clock_i) begin
    for (int n = 0; n < 4; n++) begin
      analog_o[16*n+:16] <= adc(mv_i[16*n+:16]);
      thermistor_o[16*n+:16] <= ptc_i[16*n+:16];
    end
  end
endmodule

/* File: tb/fts_top_tb.sv */
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the supervisor
module fts_top_tb
  import fts_pkg::*;
;
  typedef struct {
    logic is_read;
    logic [31:0] mask;
    logic [31:0] value;
  } fts_note_type;
  fts_note_type notes[$];
  fts_note_type note;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic read_d = 1'b0;
  logic look = 1'b0;
  logic [3:0] os_trip = 4'h0;
  logic [3:0] os_soft = 4'h0;
  logic [15:0] height1 = 16'h0000;
  logic [15:0] height2 = 16'h0000;
  logic [63:0] volts = 64'h0000_0000_0000_0000;
  logic [63:0] ptc = 64'h0000_0000_0000_0000;
  logic reset_action = 1'b0;
  logic [19:0] seed = 20'h1_5E20;
  logic [15:0] base;
  logic [63:0] ain_w;
  logic [63:0] therm_w;
  logic [31:0] rdata;
  logic [3:0] trip_f;
  logic [3:0] soft_f;
  logic [3:0] ptc_ind;
  logic [3:0] ain_ind;
  logic dev_t;
  logic dev_s;
  logic safety;
  logic out_a;
  logic out_b;
  logic irq;
  int fails = 0;
  int comparisons = 0;
  wire logic [21:0] obs = {trip_f, soft_f, dev_t, dev_s, ptc_ind, ain_ind,
    safety, out_a, out_b, irq};
  // Disabled thermistor channels carry random readings, so their live bits
  // are left out of every comparison
  localparam logic [21:0] idle_out = 22'h00_000E;
  localparam logic [21:0] mask_all = 22'h3F_F2FF;
  localparam logic [21:0] mask_out = 22'h3F_F00F;
  logic [21:0] act_out [4] = '{22'h00_000E, 22'h00_0008, 22'h00_000A,
    22'h00_000C};
  logic [31:0] cfg_list [3] = '{32'h0000_0022, 32'h0000_0035, 32'h0000_0021};

  // Free-running clock, 40 ns period
  always #20 clock_i = ~clock_i;

  fts_sensor_model fts_sensor_model_i (.clock_i(clock_i), .mv_i(volts),
    .ptc_i(ptc), .analog_o(ain_w), .thermistor_o(therm_w));
  fts_top fts_top_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata),
    .overspeed_trip_i(os_trip), .overspeed_soft_i(os_soft),
    .height1_mm_i(height1), .height2_mm_i(height2), .thermistor_i(therm_w),
    .analog_i(ain_w), .reset_action_i(reset_action),
    .motor1_overspeed_trip_flag_o(trip_f[0]),
    .motor2_overspeed_trip_flag_o(trip_f[1]),
    .drum1_overspeed_trip_flag_o(trip_f[2]),
    .drum2_overspeed_trip_flag_o(trip_f[3]),
    .motor1_overspeed_soft_flag_o(soft_f[0]),
    .motor2_overspeed_soft_flag_o(soft_f[1]),
    .drum1_overspeed_soft_flag_o(soft_f[2]),
    .drum2_overspeed_soft_flag_o(soft_f[3]),
    .height_deviation_trip_fault_o(dev_t),
    .height_deviation_soft_fault_o(dev_s),
    .thermistor_soft_indication_o(ptc_ind),
    .analog_soft_indication_o(ain_ind), .safety_output_o(safety),
    .soft_stop_output_a_o(out_a), .soft_stop_output_b_o(out_b),
    .irq_o(irq));

  // ==========================================================
  // Helpers
  function automatic logic [19:0] lfsr(input logic [19:0] s);
    return {s[18:0], s[19] ^ s[16]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Strobe drops for a cycle so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{1'b1, 32'hFFFF_FFFF, e});
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Let the pin synchronisers settle, then ask the monitor to look
  task automatic expect_o(input logic [21:0] m, input logic [21:0] e);
    seed = lfsr(seed);
    ptc[15:0] <= seed[15:0];
    ptc[47:32] <= {seed[19:16], seed[11:0]};
    repeat (9) @(posedge clock_i);
    notes.push_back('{1'b0, {10'h000, m}, {10'h000, e & m}});
    look <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
  endtask
  task automatic reset_req();
    reset_action <= 1'b1;
    repeat (6) @(posedge clock_i);
    reset_action <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  // Monitor: each result takes the oldest note off the queue
  always @(posedge clock_i) begin
    read_d <= read_i;
    if ((look || read_d) && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.is_read)
        check(rdata, note.value);
      else
        check({10'h000, obs} & note.mask, note.value);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    seed = lfsr(seed);
    base = {3'h0, seed[12:0]};
    height1 <= base;
    height2 <= base;
    wr(ADDR_CONFIG, 32'h0000_0025);
    wr(ADDR_DEV_LEVELS, 32'h8032_0064);
    wr(ADDR_PTC_LEVEL + 8'h04, 32'h0000_0064);
    wr(ADDR_AIN_LEVEL, 32'h03E8_07D0);
    rd(ADDR_ID, BLOCK_ID);
    rd(8'h4C, 32'h0000_0000);
    expect_o(mask_all, idle_out);
    for (int i = 0; i < 4; i++) begin
      os_trip[i] <= 1'b1;
      expect_o(mask_all, (22'h04_0000 << i) | 22'h00_0006);
      reset_req();
      expect_o(mask_all, (22'h04_0000 << i) | 22'h00_0006);
      os_trip[i] <= 1'b0;
      expect_o(mask_all, (22'h04_0000 << i) | 22'h00_0006);
      reset_req();
      os_soft[i] <= 1'b1;
      expect_o(mask_all, (22'h00_4000 << i) | 22'h00_0008);
      os_soft[i] <= 1'b0;
      expect_o(mask_all, (22'h00_4000 << i) | 22'h00_0008);
      reset_req();
      expect_o(mask_all, idle_out);
    end
    // Second encoder higher: the deviation is negative and must not trip
    height2 <= base + 16'h003C;
    expect_o(mask_all, idle_out);
    for (int a = 1; a < 4; a++) begin
      wr(ADDR_DEV_LEVELS, {2'(a), 30'h0032_0064});
      height2 <= base - 16'h003C;
      expect_o(mask_all, act_out[a] | 22'h00_1000);
      height2 <= base;
      reset_req();
    end
    wr(ADDR_MASK, 32'h0000_0004);
    height2 <= base - 16'h0078;
    expect_o(mask_all, 22'h00_3005);
    wr(ADDR_MASK, 32'h0000_0000);
    expect_o(mask_all, 22'h00_3004);
    wr(ADDR_MASK, 32'h0000_0004);
    height2 <= base;
    reset_req();
    expect_o(mask_all, 22'h00_000F);
    wr(ADDR_STATUS, 32'h0000_0004);
    expect_o(mask_all, idle_out);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CONFIG, cfg_list[k]);
      height2 <= base - 16'h0078;
      expect_o(mask_all, k == 2 ? 22'h00_3005 : idle_out);
      height2 <= base;
      reset_req();
      wr(ADDR_STATUS, 32'h0000_0004);
    end
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_PTC_ACTION, {28'h000_0000, 2'(a), 2'h0});
      ptc[31:16] <= 16'h0064;
      expect_o(a ? mask_all : mask_out, act_out[a] | 22'h00_0200);
      reset_req();
      expect_o(mask_out, act_out[a]);
      ptc[31:16] <= 16'h0063;
      expect_o(mask_all, act_out[a]);
      reset_req();
      expect_o(mask_all, idle_out);
    end
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_AIN_ACTION, 32'(a));
      volts[15:0] <= a[0] ? 16'hF7CC : 16'h0834;
      expect_o(a ? mask_all : mask_out, act_out[a] | 22'h00_0010);
      volts[15:0] <= 16'h05DC;
      reset_req();
      expect_o(mask_all, act_out[a]);
      volts[15:0] <= 16'hFE0C;
      // Converter and sampling stages must carry the low reading first
      repeat (4) @(posedge clock_i);
      wr(ADDR_CONTROL, 32'h0000_0001);
      expect_o(mask_all, idle_out);
    end
    volts[15:0] <= 16'h07D0;
    expect_o(mask_all, idle_out);
    stop_test();
  end

  // Watchdog: the sequence needs well under a tenth of this span
  initial begin
    #800000;
    fails++;
    stop_test();
  end
endmodule
